// [hca_pkg.sv]
package hca_pkg;

  // ****************************************************************
  // Processor port numbers
  // ****************************************************************
  localparam logic [7:0] PORT_SEL_STAT = 8'h60;
  localparam logic [7:0] PORT_SEL_ADCM = 8'h61;
  localparam logic [7:0] PORT_DS_CTRL  = 8'h62;
  localparam logic [7:0] PORT_XADDR    = 8'h63;
  localparam logic [7:0] PORT_BUF12    = 8'h64;
  localparam logic [7:0] PORT_BUF34    = 8'h65;
  localparam logic [7:0] PORT_FSTAT    = 8'h66;
  localparam logic [7:0] PORT_CTRL     = 8'h67;
  localparam logic [7:0] PORT_SOURCE   = 8'h77;

  // ****************************************************************
  // Halfword bit positions (bit 0.0 is index 15, bit 1.7 is index 0)
  // ****************************************************************
  localparam int C67_PRG_IRQ  = 6;
  localparam int C67_EN_REQ   = 3;
  localparam int C67_EMU_SET  = 2;
  localparam int C67_EMU_RST  = 1;
  localparam int C67_EN_RST   = 0;
  localparam int C62_OUTBOUND = 15;
  localparam int C62_NFINAL   = 11;
  localparam int C62_RST_SEL  = 10;
  localparam int C62_RST_DS   = 9;
  localparam int C62_PRG_REQ  = 8;
  localparam int C77_DS_IRQ   = 4;
  localparam int C77_SEL_IRQ  = 3;
  localparam int C60_NORMAL   = 15;
  localparam int C67_ENABLED  = 3;

  // ****************************************************************
  // Sense bit positions within the byte (sense bit 0 is index 7)
  // ****************************************************************
  localparam int SNS_REJECT  = 7;
  localparam int SNS_INTERV  = 6;
  localparam int SNS_BOCHK   = 5;
  localparam int SNS_EQCHK   = 4;
  localparam int SNS_DCHK    = 3;
  localparam int SNS_UNUSED  = 2;
  localparam int SNS_NOTINIT = 1;
  localparam int SNS_ABORT   = 0;

  // ****************************************************************
  // Commands and status bytes
  // ****************************************************************
  localparam logic [7:0] CMD_TIO    = 8'h00;
  localparam logic [7:0] CMD_NOOP   = 8'h03;
  localparam logic [7:0] CMD_SENSE  = 8'h04;
  localparam logic [1:0] CMD_WR_LOW = 2'h1;
  localparam logic [1:0] CMD_RD_LOW = 2'h2;
  localparam logic [7:0] ST_ZERO    = 8'h00;
  localparam logic [7:0] ST_CE_DE   = 8'h0c;
  localparam logic [7:0] ST_CE_DE_UC = 8'h0e;
  localparam logic [1:0] CNT_RESET  = 2'h1;
  localparam int         SYNC_STAGES = 2;

  typedef enum logic [2:0] {
    HCA_IDLE     = 3'b000,
    HCA_SEL_ADDR = 3'b001,
    HCA_SEL_STAT = 3'b010,
    HCA_REQ      = 3'b011,
    HCA_XF_ADDR  = 3'b100,
    HCA_XF_DATA  = 3'b101,
    HCA_XF_GAP   = 3'b110,
    HCA_XF_STAT  = 3'b111
  } hca_state_t;

  typedef struct packed {
    logic [7:0] bus_out;
    logic       bus_out_par;
    logic       address_out;
    logic       select_out;
    logic       command_out;
    logic       service_out;
  } hca_chan_in_t;

  typedef struct packed {
    logic [7:0] bus_in;
    logic       bus_in_par;
    logic       operational_in;
    logic       address_in;
    logic       status_in;
    logic       service_in;
    logic       request_in;
  } hca_chan_out_t;

  typedef struct packed {
    logic        strobe;
    logic        write;
    logic [7:0]  port;
    logic [15:0] data;
  } hca_io_req_t;

endpackage

// [hca_sync.sv]
`timescale 1ns/1ps

// ******************************************************************
// Two-stage synchroniser for channel tag and bus pins
// ******************************************************************
module hca_sync #(
  parameter int WIDTH = 13
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // The first stage feeds only the second, so no logic sees a metastable level.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// [hca_addr_match.sv]
`timescale 1ns/1ps

// ******************************************************************
// Native and emulation address recognition
// ******************************************************************
module hca_addr_match (
  input  wire logic [7:0] addr,
  input  wire logic [7:0] native_addr,
  input  wire logic [7:0] emu_low,
  input  wire logic [7:0] emu_high,
  input  wire logic       emu_on,
  output logic            hit,
  output logic            is_emu
);

  // Emulation range only counts once the program has made emulation operational.
  assign is_emu = emu_on && (addr >= emu_low) && (addr <= emu_high) && (addr != native_addr);
  assign hit    = (addr == native_addr) || is_emu;

endmodule

// [hca_core.sv]
// Functional notes
// - Port 67 bit 1.4 enables interface, reflected.
// - Port 67 bit 1.1 raises program interrupt.
// - Port 77 byte 1 flags data/status interrupt.
// - Port 62 bit 0.7 marks program request.
// - Transfer address byte identifies device on bus.
// - Port 66 loads native final status byte.
// - Port 62 bit 0.4 starts final status.
// - Selection with a non-autonomous command sets port 77 and port 60 flags.
// - Port 61 returns captured address and command.
// - Port 64 loads data buffer bytes one, two.
// - Port 62 outbound start, reset selection, count.
// - Sense byte bit layout fixed.
// - Hardware sets intervention bit on read/write.
// - Bus-out parity error sets sense bit 2.
// - Internal check sets sense bit 3.
// - Disconnect during sense ends with CE DE UC.
// - Respond only to native or emulation addresses.
// - Store address, echo it, capture command.
// - Native No-Op/TIO, emulation No-Op autonomous.
// - Autonomous commands present initial status.
// - Decode only while enabled; emulation needs enable.
// - Emulation selection overrides pending transfer request.
// - Byte count encoding in bits 1.6, 1.7.
`timescale 1ns/1ps

module hca_core (
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire hca_pkg::hca_io_req_t   io_req,
  output logic [15:0]                 io_rdata,
  output logic                        io_ack,
  output logic                        level_three_interrupt,
  input  wire logic [7:0]             native_addr,
  input  wire logic [7:0]             emu_low,
  input  wire logic [7:0]             emu_high,
  input  wire hca_pkg::hca_chan_in_t  chan_pins,
  output hca_pkg::hca_chan_out_t      chan_out
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic odd_par(input logic [7:0] b);
    odd_par = ~^b;
  endfunction

  function automatic logic is_rdwr(input logic [7:0] c);
    is_rdwr = (c[1:0] == hca_pkg::CMD_WR_LOW) || (c[1:0] == hca_pkg::CMD_RD_LOW);
  endfunction

  // ****************************************************************
  // Pin synchronisation and address compare
  // ****************************************************************
  hca_pkg::hca_chan_in_t ch;
  hca_sync #(.WIDTH($bits(hca_pkg::hca_chan_in_t))) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in (chan_pins),
    .sync_out (ch)
  );

  logic enabled_reg;
  logic emu_on_reg;
  logic addr_hit;
  logic addr_emu;
  hca_addr_match u_match (
    .addr        (ch.bus_out),
    .native_addr (native_addr),
    .emu_low     (emu_low),
    .emu_high    (emu_high),
    .emu_on      (emu_on_reg),
    .hit         (addr_hit),
    .is_emu      (addr_emu)
  );

  // ****************************************************************
  // State
  // ****************************************************************
  hca_pkg::hca_state_t state_reg, state_next;
  logic [7:0] sel_addr_reg;
  logic [7:0] sel_cmd_reg;
  logic       sel_emu_reg;
  logic [7:0] xfer_addr_reg;
  logic [7:0] emu_stat_reg;
  logic [7:0] fstat_reg;
  logic [7:0] data_buf [4];
  logic [1:0] cnt_reg;
  logic [1:0] idx_reg;
  logic       outb_reg;
  logic       nfin_reg;
  logic       ds_pend_reg;
  logic       prog_reg;
  logic       sel_pend_reg;
  logic [7:0] sense_hw_reg;
  logic [7:0] stat_byte_reg;
  logic       disc_reg;

  // ****************************************************************
  // Processor instruction decode (one halfword per instruction)
  // ****************************************************************
  // halfword transfer
  wire        wr    = io_req.strobe && io_req.write;
  wire        rd    = io_req.strobe && !io_req.write;
  wire [15:0] wd    = io_req.data;
  wire        wr62  = wr && (io_req.port == hca_pkg::PORT_DS_CTRL);
  wire        wr67  = wr && (io_req.port == hca_pkg::PORT_CTRL);
  wire        known = (io_req.port inside {hca_pkg::PORT_SEL_STAT, hca_pkg::PORT_SEL_ADCM, hca_pkg::PORT_DS_CTRL,
                       hca_pkg::PORT_XADDR, hca_pkg::PORT_BUF12, hca_pkg::PORT_BUF34, hca_pkg::PORT_FSTAT,
                       hca_pkg::PORT_CTRL, hca_pkg::PORT_SOURCE});
  wire        rst_sel = wr62 && wd[hca_pkg::C62_RST_SEL];
  wire        rst_ds  = wr62 && wd[hca_pkg::C62_RST_DS];

  // ****************************************************************
  // Channel events
  // ****************************************************************
  // decode gated by enable
  wire sel_start = enabled_reg && ch.address_out && ch.select_out && addr_hit;
  wire cmd_par_ok = odd_par(ch.bus_out) == ch.bus_out_par;
  wire [7:0] cmd = ch.bus_out;
  wire auto_cmd = (cmd == hca_pkg::CMD_NOOP) || (!sel_emu_reg && cmd == hca_pkg::CMD_TIO);
  wire cmd_take = (state_reg == hca_pkg::HCA_SEL_ADDR) && ch.command_out;
  wire abandon = (state_reg == hca_pkg::HCA_REQ) && sel_start && emu_on_reg;
  wire svc_take = ch.service_out;
  wire last_byte = (idx_reg == cnt_reg - 2'h1);
  wire data_done = (state_reg == hca_pkg::HCA_XF_DATA) && svc_take && !ch.address_out && last_byte;
  wire stat_done = (state_reg == hca_pkg::HCA_XF_STAT) && svc_take;
  wire disconnect = (state_reg == hca_pkg::HCA_XF_DATA) && ch.address_out && !ch.select_out;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      hca_pkg::HCA_IDLE: begin
        if (sel_start) begin
          state_next = hca_pkg::HCA_SEL_ADDR;
        end else if (enabled_reg && (outb_reg || nfin_reg)) begin
          state_next = hca_pkg::HCA_REQ;
        end
      end
      hca_pkg::HCA_SEL_ADDR: begin
        if (ch.command_out) begin
          state_next = hca_pkg::HCA_SEL_STAT;
        end
      end
      hca_pkg::HCA_SEL_STAT: begin
        if (svc_take) begin
          state_next = hca_pkg::HCA_IDLE;
        end
      end
      hca_pkg::HCA_REQ: begin
        if (abandon) begin
          state_next = hca_pkg::HCA_SEL_ADDR;
        end else if (ch.select_out && !ch.address_out) begin
          state_next = hca_pkg::HCA_XF_ADDR;
        end
      end
      hca_pkg::HCA_XF_ADDR: begin
        if (ch.command_out) begin
          state_next = outb_reg ? hca_pkg::HCA_XF_DATA : hca_pkg::HCA_XF_STAT;
        end
      end
      hca_pkg::HCA_XF_DATA: begin
        if (disconnect) begin
          state_next = hca_pkg::HCA_XF_STAT;
        end else if (svc_take) begin
          state_next = last_byte ? hca_pkg::HCA_IDLE : hca_pkg::HCA_XF_GAP;
        end
      end
      hca_pkg::HCA_XF_GAP: begin
        if (!ch.service_out) begin
          state_next = hca_pkg::HCA_XF_DATA;
        end
      end
      hca_pkg::HCA_XF_STAT: begin
        if (svc_take) begin
          state_next = hca_pkg::HCA_IDLE;
        end
      end
      default: state_next = hca_pkg::HCA_IDLE;
    endcase
  end

  // ****************************************************************
  // Control latches: hardware sets win over program resets
  // ****************************************************************
  // interface enable latch
  wire en_next = (enabled_reg && !(wr67 && wd[hca_pkg::C67_EN_RST])) || (wr67 && wd[hca_pkg::C67_EN_REQ]);
  wire emu_next = (emu_on_reg && !(wr67 && wd[hca_pkg::C67_EMU_RST])) || (wr67 && wd[hca_pkg::C67_EMU_SET]);
  wire prg_set = wr67 && wd[hca_pkg::C67_PRG_IRQ];
  wire ds_set = prg_set || data_done || stat_done;
  wire ds_pend_next = (ds_pend_reg && !rst_ds) || ds_set;
  wire prog_next = (prog_reg && !rst_ds && !data_done && !stat_done) || prg_set;
  wire sel_irq_set = cmd_take && !auto_cmd;
  wire sel_pend_next = (sel_pend_reg && !rst_sel) || sel_irq_set;
  wire outb_next = wr62 ? wd[hca_pkg::C62_OUTBOUND] : (outb_reg && !data_done && !abandon && !disconnect);
  wire nfin_next = wr62 ? wd[hca_pkg::C62_NFINAL] : (nfin_reg && !stat_done && !abandon);

  // intervention while a read or write command runs
  wire interv = sel_pend_reg && is_rdwr(sel_cmd_reg);
  // bus-out check on the command byte
  wire bo_set = cmd_take && !cmd_par_ok;
  // equipment check on a bad processor transfer
  wire eq_set = io_req.strobe && !known;
  wire [7:0] sense_next = {1'b0, interv,
                           (sense_hw_reg[hca_pkg::SNS_BOCHK] && !rst_sel) || bo_set,
                           (sense_hw_reg[hca_pkg::SNS_EQCHK] && !rst_sel) || eq_set, 4'h0};

  wire [7:0] init_stat = (cmd == hca_pkg::CMD_NOOP) ? hca_pkg::ST_CE_DE :
                         (nfin_reg ? fstat_reg : hca_pkg::ST_ZERO);
  // status source; a disconnect forces CE DE UC below.
  wire [7:0] xf_stat = nfin_reg ? fstat_reg : emu_stat_reg;
  // hardware sense bits merge into the first sense byte
  wire [7:0] out_byte = (sel_cmd_reg == hca_pkg::CMD_SENSE && idx_reg == 2'h0) ?
                        (data_buf[0] | sense_hw_reg) : data_buf[idx_reg];

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg    <= hca_pkg::HCA_IDLE;
      enabled_reg  <= 1'b0;
      emu_on_reg   <= 1'b0;
      ds_pend_reg  <= 1'b0;
      prog_reg     <= 1'b0;
      sel_pend_reg <= 1'b0;
      outb_reg     <= 1'b0;
      nfin_reg     <= 1'b0;
      sense_hw_reg <= 8'h00;
      disc_reg     <= 1'b0;
    end else begin
      state_reg    <= state_next;
      enabled_reg  <= en_next;
      emu_on_reg   <= emu_next;
      ds_pend_reg  <= ds_pend_next;
      prog_reg     <= prog_next;
      sel_pend_reg <= sel_pend_next;
      outb_reg     <= outb_next;
      nfin_reg     <= nfin_next;
      sense_hw_reg <= sense_next;
      disc_reg     <= disconnect || (disc_reg && !rst_sel);
    end
  end

  // ****************************************************************
  // Program-loaded bytes and captured selection data
  // ****************************************************************
  // Data registers need no reset; software loads them before use.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_reg <= hca_pkg::CNT_RESET;
      idx_reg <= 2'h0;
    end else begin
      if (wr62) begin
        cnt_reg <= wd[1:0];
      end
      if (state_reg == hca_pkg::HCA_XF_ADDR) begin
        idx_reg <= 2'h0;
      end else if (state_reg == hca_pkg::HCA_XF_DATA && svc_take) begin
        idx_reg <= idx_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if ((state_reg == hca_pkg::HCA_IDLE || abandon) && sel_start) begin
      sel_addr_reg <= ch.bus_out;
      sel_emu_reg  <= addr_emu;
    end
    if (cmd_take) begin
      sel_cmd_reg <= cmd;
    end
    if (wr && io_req.port == hca_pkg::PORT_XADDR) begin
      xfer_addr_reg <= wd[15:8];
      emu_stat_reg  <= wd[7:0];
    end
    // data buffer bytes one and two
    if (wr && io_req.port == hca_pkg::PORT_BUF12) begin
      data_buf[0] <= wd[15:8];
      data_buf[1] <= wd[7:0];
    end
    if (wr && io_req.port == hca_pkg::PORT_BUF34) begin
      data_buf[2] <= wd[15:8];
      data_buf[3] <= wd[7:0];
    end
    if (wr && io_req.port == hca_pkg::PORT_FSTAT) begin
      fstat_reg <= wd[7:0];
    end
    if (cmd_take) begin
      stat_byte_reg <= init_stat;
    end else if (disconnect) begin
      stat_byte_reg <= hca_pkg::ST_CE_DE_UC;
    end else if (state_reg == hca_pkg::HCA_XF_ADDR) begin
      stat_byte_reg <= xf_stat;
    end
  end

  // ****************************************************************
  // Processor read answers
  // ****************************************************************
  wire [15:0] rd_mux =
    (io_req.port == hca_pkg::PORT_SOURCE)   ? {11'h000, ds_pend_reg, sel_pend_reg, 3'h0} :
    (io_req.port == hca_pkg::PORT_SEL_STAT) ? {sel_pend_reg, 15'h0000} :
    (io_req.port == hca_pkg::PORT_SEL_ADCM) ? {sel_addr_reg, sel_cmd_reg} :
    (io_req.port == hca_pkg::PORT_DS_CTRL)  ? {outb_reg, 3'h0, nfin_reg, disc_reg, 1'b0, prog_reg,
                                               5'h00, idx_reg == 2'h0, idx_reg} :
    (io_req.port == hca_pkg::PORT_XADDR)    ? {xfer_addr_reg, 8'h00} :
    (io_req.port == hca_pkg::PORT_BUF12)    ? {data_buf[0], data_buf[1]} :
    (io_req.port == hca_pkg::PORT_BUF34)    ? {data_buf[2], data_buf[3]} :
    (io_req.port == hca_pkg::PORT_FSTAT)    ? {8'h00, fstat_reg} :
    (io_req.port == hca_pkg::PORT_CTRL)     ? {native_addr, 4'h0, enabled_reg, emu_on_reg, 2'h0} : 16'h0000;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      io_rdata <= 16'h0000;
      io_ack   <= 1'b0;
    end else begin
      io_ack <= io_req.strobe;
      if (rd) begin
        io_rdata <= rd_mux;
      end
    end
  end

  assign level_three_interrupt = ds_pend_reg || sel_pend_reg;

  // ****************************************************************
  // Channel bus-in and tags
  // ****************************************************************
  wire [7:0] bus_sel = (state_reg == hca_pkg::HCA_SEL_ADDR) ? sel_addr_reg :
                       (state_reg == hca_pkg::HCA_XF_ADDR)  ? xfer_addr_reg :
                       (state_reg == hca_pkg::HCA_XF_DATA)  ? out_byte :
                       (state_reg == hca_pkg::HCA_SEL_STAT || state_reg == hca_pkg::HCA_XF_STAT) ?
                       stat_byte_reg : 8'h00;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      chan_out <= '0;
    end else begin
      chan_out.bus_in         <= bus_sel;
      chan_out.bus_in_par     <= odd_par(bus_sel);
      chan_out.operational_in <= !(state_reg inside {hca_pkg::HCA_IDLE, hca_pkg::HCA_REQ});
      chan_out.address_in     <= state_reg inside {hca_pkg::HCA_SEL_ADDR, hca_pkg::HCA_XF_ADDR};
      chan_out.status_in      <= state_reg inside {hca_pkg::HCA_SEL_STAT, hca_pkg::HCA_XF_STAT};
      chan_out.service_in     <= state_reg == hca_pkg::HCA_XF_DATA;
      chan_out.request_in     <= state_reg == hca_pkg::HCA_REQ; // Same state as bus_sel, so tag and byte align.
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_enable_reflect: assert property (wr67 && wd[hca_pkg::C67_EN_REQ] |=> enabled_reg)
    else $error("enable request not reflected");
  a_prog_irq: assert property (prg_set && !rst_ds |=> ds_pend_reg && prog_reg && level_three_interrupt)
    else $error("program interrupt not raised");
  a_source_read: assert property (rd && io_req.port == hca_pkg::PORT_SOURCE
    |=> io_ack && io_rdata[hca_pkg::C77_DS_IRQ] == $past(ds_pend_reg))
    else $error("source bit mismatch");
  a_prog_bit: assert property (rd && io_req.port == hca_pkg::PORT_DS_CTRL
    |=> io_rdata[hca_pkg::C62_PRG_REQ] == $past(prog_reg))
    else $error("program cause bit mismatch");
  a_xfer_addr: assert property (state_reg == hca_pkg::HCA_XF_ADDR |=> chan_out.bus_in == $past(xfer_addr_reg))
    else $error("transfer address not driven");
  a_final_start: assert property (state_reg == hca_pkg::HCA_IDLE && !sel_start && enabled_reg
    && wr62 && wd[hca_pkg::C62_NFINAL] |=> ##2 state_reg == hca_pkg::HCA_REQ && chan_out.request_in)
    else $error("final status request missing");
  a_sel_irq: assert property (sel_irq_set |=> sel_pend_reg)
    else $error("selection interrupt missing");
  a_sel_echo: assert property (state_reg == hca_pkg::HCA_SEL_ADDR
    |=> chan_out.address_in && chan_out.bus_in == $past(sel_addr_reg))
    else $error("address echo missing");
  a_noop_status: assert property (cmd_take && cmd == hca_pkg::CMD_NOOP
    |=> ##1 chan_out.status_in && chan_out.bus_in == hca_pkg::ST_CE_DE && !sel_pend_reg)
    else $error("no-op initial status wrong");
  a_abandon: assert property (abandon |=> state_reg == hca_pkg::HCA_SEL_ADDR && !outb_reg && !nfin_reg)
    else $error("selection did not override request");

  c_sense_done: cover property (data_done && sel_cmd_reg == hca_pkg::CMD_SENSE);
  c_noop: cover property (cmd_take && cmd == hca_pkg::CMD_NOOP);
  c_abandon: cover property (abandon);
  c_disconnect: cover property (disconnect);

endmodule

// [hca_chan_model.sv]
`timescale 1ns/1ps
module hca_chan_model (
  input  wire logic                   core_clk,
  input  wire hca_pkg::hca_chan_out_t chan_out,
  output hca_pkg::hca_chan_in_t       chan_pins
);
  logic [15:0] got;
  logic        hit;
  logic        tags_ok;
  int          n;
  wire         tag_in = chan_out.status_in | chan_out.service_in;
  initial chan_pins = '0;
  // Selection when sel is set, else an answer to request in; bus out has odd parity until the release, which drives even parity.
  task automatic seq(input logic sel, input logic [7:0] a, c);
    for (n = 0; n < 40 && !sel && !chan_out.request_in; n++) @(posedge core_clk);
    chan_pins <= '{a, ~^a, sel, 1'b1, 1'b0, 1'b0};
    for (n = 0; n < 40 && !chan_out.address_in; n++) @(posedge core_clk);
    hit = n < 40;
    got[15:8] = chan_out.bus_in;
    tags_ok = chan_out.operational_in && (chan_out.bus_in_par == ~^chan_out.bus_in);
    if (hit) chan_pins <= '{c, ~^c, 1'b0, 1'b1, 1'b1, 1'b0};
    for (n = 0; hit && n < 40 && !tag_in; n++) @(posedge core_clk);
    got[7:0] = chan_out.bus_in;
    tags_ok = tags_ok && chan_out.operational_in && (chan_out.bus_in_par == ~^chan_out.bus_in);
    if (hit) chan_pins <= '{c, ~^c, 1'b0, 1'b1, 1'b0, 1'b1};
    for (n = 0; hit && n < 40 && tag_in; n++) @(posedge core_clk);
    // A released bus shows the inverse byte, so a stale copy cannot pass.
    chan_pins <= '{~c, ^c, 1'b0, 1'b0, 1'b0, 1'b0};
    repeat (3) @(posedge core_clk);
  endtask
endmodule

// [testbench.sv]
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0] NAT = 8'h40;
  logic        core_clk, rst_n = 1'b0, io_ack, level_three_interrupt;
  logic [15:0] io_rdata;
  int          n_errors = 0, compares = 0, cyc = 0;
  hca_pkg::hca_io_req_t   io_req = '0;
  hca_pkg::hca_chan_in_t  chan_pins;
  hca_pkg::hca_chan_out_t chan_out;
  hca_core i_hca_core (.core_clk(core_clk), .rst_n(rst_n), .io_req(io_req), .io_rdata(io_rdata), .io_ack(io_ack),
    .level_three_interrupt(level_three_interrupt), .native_addr(NAT), .emu_low(8'h80), .emu_high(8'h8f),
    .chan_pins(chan_pins), .chan_out(chan_out));
  hca_chan_model i_hca_chan_model (.core_clk(core_clk), .chan_out(chan_out), .chan_pins(chan_pins));
  // Free-running 200 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Count a comparison and report a mismatch.
  task automatic chk(input string w, input logic [15:0] s, e);
    compares++;
    if (s !== e) $display("[ERR] %s expected %h seen %h", w, e, s);
    if (s !== e) n_errors++;
  endtask
  // One instruction; a read is compared under mask m at the acknowledge edge.
  task automatic io(input logic wr, input logic [7:0] p, input logic [15:0] d, m = 16'hffff);
    io_req <= '{1'b1, wr, p, d};
    @(posedge core_clk);
    io_req.strobe <= 1'b0;
    @(posedge core_clk);
    chk("ack", {15'h0, io_ack}, 16'h0001);
    if (!wr) chk("read data", io_rdata & m, d & m);
  endtask
  // One channel sequence; checks whether the adapter answered and its bus in bytes.
  task automatic chan(input logic s, input logic [7:0] a, c, input logic h, input logic [15:0] e);
    i_hca_chan_model.seq(s, a, c);
    chk("answered", {15'h0, i_hca_chan_model.hit}, {15'h0, h});
    if (h) chk("bus in", i_hca_chan_model.got, e);
    if (h) chk("tags", {15'h0, i_hca_chan_model.tags_ok}, 16'h0001);
  endtask
  // Counts first, then the verdict; the run ends only here.
  task automatic wrap_up(input int extra);
    n_errors += extra;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // The tests need under 1500 cycles, so a hang past this ceiling is an error.
  always @(posedge core_clk) if (++cyc == 4000) wrap_up(1);
  // Five reset cycles, then instruction and channel sequences.
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk("reset", io_rdata | 16'(chan_out) | {15'h0, io_ack | level_three_interrupt}, 16'h0000);
    io(1'b1, 8'h67, 16'h0008);
    io(1'b0, 8'h67, {NAT, 8'h08});
    io(1'b1, 8'h67, 16'h0040);
    chk("irq", {15'h0, level_three_interrupt}, 16'h0001);
    io(1'b0, 8'h77, 16'h0010);
    io(1'b0, 8'h62, 16'h0100, 16'hff00);
    io(1'b1, 8'h63, {NAT, 8'h00});
    io(1'b1, 8'h66, 16'h0006);
    io(1'b1, 8'h62, 16'h0800);
    chan(1'b0, 8'h00, 8'h00, 1'b1, {NAT, 8'h06});
    chan(1'b1, NAT, 8'h04, 1'b1, {NAT, 8'h00});
    io(1'b0, 8'h77, 16'h0018);
    io(1'b0, 8'h60, 16'h8000, 16'hff00);
    io(1'b0, 8'h61, {NAT, 8'h04});
    io(1'b1, 8'h64, 16'h0200);
    io(1'b1, 8'h62, 16'h8401);
    io(1'b0, 8'h68, 16'h0000);
    chan(1'b0, 8'h00, 8'h00, 1'b1, {NAT, 8'h12});
    chan(1'b1, NAT, 8'h03, 1'b1, {NAT, 8'h0c});
    io(1'b0, 8'h77, 16'h0010);
    chan(1'b1, 8'h41, 8'h03, 1'b0, 16'h0);
    chan(1'b1, 8'h85, 8'h03, 1'b0, 16'h0);
    wrap_up(0);
  end
endmodule
